//--- src/dma_ctrl_defines.svh
// register offsets, field positions, reset values and timing constants
`ifndef DMA_CTRL_DEFINES_SVH
`define DMA_CTRL_DEFINES_SVH

`define OFS_IRQ_EN 16'h101c
`define OFS_MISSED 16'h1020
`define OFS_WDOG 16'h1024
`define OFS_AXI_CFG 16'h1028
`define OFS_AXI_ACT 16'h102c
`define OFS_TX_DESC 16'h1048
`define OFS_RX_DESC 16'h104c
`define OFS_TX_BUF 16'h1050
`define OFS_RX_BUF 16'h1054
`define OFS_IRQ_STAT 16'h1060

`define IRQ_EN_MASK 32'h0001_e7ff
`define NORMAL_SRC_MASK 32'h0000_4045
`define ABNORMAL_SRC_MASK 32'h0000_27ba
`define BIT_NORMAL_EN 16
`define BIT_ABNORMAL_EN 15
`define BIT_RX_DONE 6
`define BIT_RX_WDOG 9

`define OVF_CNT_LSB 17
`define OVF_CNT_MSB 27
`define OVF_STICKY 28
`define MISS_CNT_MSB 15
`define MISS_STICKY 16
`define LANE_OVF 2
`define LANE_MISS 0

`define WDOG_MSB 7
`define WDOG_UNIT_CYCLES 256
`define WDOG_PRESCALE_W 8

`define BIT_LOW_POWER_ACCEPT 31
`define BIT_WAKE_ONLY_PKT 30
`define WR_OSR_LSB 20
`define WR_OSR_MSB 21
`define RD_OSR_LSB 16
`define RD_OSR_MSB 17
`define OSR_RESET 2'h1
`define BIT_ALIGNED 12
`define BIT_BURST16 3
`define BIT_BURST8 2
`define BIT_BURST4 1
`define BIT_ANY_BURST 0
`define AXI_CFG_WMASK 32'hc033_000e

`define UNMAPPED_DATA 32'h0000_0000

`endif

//--- src/dma_ctrl_pkg.sv
// types shared by the dma control register block
package dma_ctrl_pkg;

    typedef enum logic [1:0] {
        bus_idle,
        bus_answer
    } bus_state_t;

    typedef struct packed {
        logic [1:0] write_outstanding_limit;
        logic [1:0] read_outstanding_limit;
        logic burst16_allow;
        logic burst8_allow;
        logic burst4_allow;
        logic any_burst_len_flag;
        logic aligned_beats_mirror;
        logic low_power_accept;
        logic wake_only_on_wake_pkt;
    } axi_cfg_t;

    typedef struct packed {
        logic [31:0] cur_tx_desc_ptr;
        logic [31:0] cur_rx_desc_ptr;
        logic [31:0] cur_tx_buf_ptr;
        logic [31:0] cur_rx_buf_ptr;
    } dma_ptrs_t;

    typedef struct packed {
        bus_state_t bus;
        logic waitrequest;
        logic [31:0] readdata;
        logic [31:0] irq_en;
        logic [31:0] irq_stat;
        logic [10:0] ovf_count;
        logic ovf_sticky;
        logic [15:0] miss_count;
        logic miss_sticky;
        logic [7:0] rx_irq_wdog_count;
        logic [7:0] prescale;
        logic [7:0] wdog_left;
        logic wdog_run;
        axi_cfg_t cfg;
        logic read_channel_active;
        logic write_channel_active;
        dma_ptrs_t ptrs;
        logic irq;
        logic lp_grant;
        logic wake_req;
    } ctrl_state_t;

endpackage

//--- src/dma_irq_axi_ctrl.sv
// dma interrupt enables, missed-frame counters, watchdog and axi settings
`timescale 1ns/10ps
`include "dma_ctrl_defines.svh"

// How it works
// - fatal bus error interrupt needs its bit 13 enable and abnormal enable
// - early transmit interrupt needs bit 10 enable and abnormal enable
// - receive watchdog interrupt needs bit 9 enable and abnormal enable
// - receive stopped interrupt needs bit 8 enable and abnormal enable
// - receive buffer unavailable needs bit 7 enable and abnormal enable
// - receive complete interrupt needs bit 6 enable and normal enable
// - underflow bit 5 and overflow bit 4 gated by abnormal enable
// - transmit jabber interrupt needs bit 3 enable and abnormal enable
// - transmit buffer unavailable needs bit 2 enable and normal enable
// - transmission stopped needs bit 1 enable and abnormal enable
// - transmit complete needs bit 0 enable and normal enable
// - fifo overflow count bits 27:17, sticky 28, cleared by lane 2 read
// - missed frame count bits 15:0, sticky 16, cleared by lane 0 read
// - watchdog value counts in units of 256 system clocks
// - watchdog starts after suppressed flag, expiry sets flag and stops
// - low power requests granted only while bit 31 is set
// - bit 30 picks wake on wake packet only, else any frame
// - outstanding write and read limits are field plus one, reset 1
// - burst 16, 8, 4 allowed by own enable or any-length flag
// - bit 0 reads inverse of fixed burst setting
// - bits 1 and 0 show read and write channel activity
// - four read-only dma pointers, zero after reset
// - bit 16 gates the normal sources
// - bit 15 gates the abnormal sources
module dma_irq_axi_ctrl #(
    parameter int ADDR_W = 16
) (
    input wire logic clk_sys, // system clock
    input wire logic reset, // async reset, active high
    input wire logic [ADDR_W-1:0] address, // byte address
    input wire logic read, // read request
    input wire logic write, // write request
    input wire logic [3:0] byteenable, // byte lanes
    input wire logic [31:0] writedata, // write data
    output logic [31:0] readdata, // read data
    output logic waitrequest, // stall
    input wire logic [31:0] irq_src_set, // status source set pulses
    input wire logic [31:0] irq_src_clr, // status source clear pulses
    input wire logic rx_fifo_overflow, // fifo layer overflow pulse
    input wire logic rx_frame_discarded, // frame dropped, no buffer
    input wire logic rx_frame_done, // receive transfer finished
    input wire logic rx_done_suppressed, // descriptor suppressed flag
    input wire logic fixed_burst_setting, // fixed burst from bus mode
    input wire logic aligned_beats, // aligned beats from bus mode
    input wire logic rd_busy, // axi read channel moving data
    input wire logic wr_busy, // axi write channel moving data
    input wire logic ptr_load, // dma pointer update strobe
    input wire dma_ctrl_pkg::dma_ptrs_t ptr_in, // new pointer values
    input wire logic low_power_req, // low power request from clock ctl
    input wire logic rx_any_frame, // any frame received
    input wire logic rx_wake_pkt, // magic or wake-up packet received
    output logic irq, // interrupt output
    output logic low_power_grant, // low power accepted
    output logic wake_request, // request to leave low power
    output dma_ctrl_pkg::axi_cfg_t axi_cfg // axi master settings
);

    dma_ctrl_pkg::ctrl_state_t st;
    dma_ctrl_pkg::ctrl_state_t next_st;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [15:0] ofs);
        hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] be,
                                          input logic [31:0] wmask);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
        merge = (old & ~m) | (d & m);
    endfunction

    logic [31:0] irq_pending;
    logic [31:0] cfg_word;
    logic [31:0] cfg_new;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        irq_pending = 32'h0000_0000;
        cfg_word = 32'h0000_0000;
        cfg_new = 32'h0000_0000;

        // read-only inputs mirrored
        next_st.read_channel_active = rd_busy;
        next_st.write_channel_active = wr_busy;
        next_st.cfg.any_burst_len_flag = ~fixed_burst_setting;
        next_st.cfg.aligned_beats_mirror = aligned_beats;
        if (ptr_load) begin
            next_st.ptrs = ptr_in;
        end

        // counters with sticky overflow
        if (rx_fifo_overflow) begin
            {next_st.ovf_sticky, next_st.ovf_count} =
                {st.ovf_sticky, 11'h000} |
                {1'b0, st.ovf_count} + 12'h001;
        end
        if (rx_frame_discarded) begin
            {next_st.miss_sticky, next_st.miss_count} =
                {st.miss_sticky, 16'h0000} |
                {1'b0, st.miss_count} + 17'h0_0001;
        end

        // bus slave: one answer cycle per request
        next_st.waitrequest = 1'b1;
        unique case (st.bus)
            dma_ctrl_pkg::bus_idle: begin
                if (read || write) begin
                    next_st.bus = dma_ctrl_pkg::bus_answer;
                    next_st.waitrequest = 1'b0;
                    next_st.readdata = `UNMAPPED_DATA;
                    if (read) begin
                        if (hit(address, `OFS_IRQ_EN)) begin
                            next_st.readdata = st.irq_en;
                        end else if (hit(address, `OFS_IRQ_STAT)) begin
                            next_st.readdata = st.irq_stat;
                        end else if (hit(address, `OFS_MISSED)) begin
                            next_st.readdata = {3'h0, st.ovf_sticky,
                                st.ovf_count, st.miss_sticky,
                                st.miss_count};
                            if (byteenable[`LANE_OVF] && !rx_fifo_overflow)
                            begin
                                next_st.ovf_count = 11'h000;
                                next_st.ovf_sticky = 1'b0;
                            end
                            if (byteenable[`LANE_MISS]
                                && !rx_frame_discarded) begin
                                next_st.miss_count = 16'h0000;
                                next_st.miss_sticky = 1'b0;
                            end
                        end else if (hit(address, `OFS_WDOG)) begin
                            next_st.readdata = {24'h00_0000,
                                st.rx_irq_wdog_count};
                        end else if (hit(address, `OFS_AXI_CFG)) begin
                            next_st.readdata = {st.cfg.low_power_accept,
                                st.cfg.wake_only_on_wake_pkt, 8'h00,
                                st.cfg.write_outstanding_limit, 2'h0,
                                st.cfg.read_outstanding_limit, 3'h0,
                                st.cfg.aligned_beats_mirror, 8'h00,
                                st.cfg.burst16_allow, st.cfg.burst8_allow,
                                st.cfg.burst4_allow,
                                st.cfg.any_burst_len_flag};
                        end else if (hit(address, `OFS_AXI_ACT)) begin
                            next_st.readdata = {30'h0000_0000,
                                st.read_channel_active,
                                st.write_channel_active};
                        end else if (hit(address, `OFS_TX_DESC)) begin
                            next_st.readdata = st.ptrs.cur_tx_desc_ptr;
                        end else if (hit(address, `OFS_RX_DESC)) begin
                            next_st.readdata = st.ptrs.cur_rx_desc_ptr;
                        end else if (hit(address, `OFS_TX_BUF)) begin
                            next_st.readdata = st.ptrs.cur_tx_buf_ptr;
                        end else if (hit(address, `OFS_RX_BUF)) begin
                            next_st.readdata = st.ptrs.cur_rx_buf_ptr;
                        end
                    end else begin
                        if (hit(address, `OFS_IRQ_EN)) begin
                            next_st.irq_en = merge(st.irq_en, writedata,
                                byteenable, `IRQ_EN_MASK);
                        end else if (hit(address, `OFS_WDOG)) begin
                            if (byteenable[0]) begin
                                next_st.rx_irq_wdog_count =
                                    writedata[`WDOG_MSB:0];
                            end
                        end else if (hit(address, `OFS_AXI_CFG)) begin
                            cfg_word = {st.cfg.low_power_accept,
                                st.cfg.wake_only_on_wake_pkt, 8'h00,
                                st.cfg.write_outstanding_limit, 2'h0,
                                st.cfg.read_outstanding_limit, 8'h00,
                                4'h0, st.cfg.burst16_allow,
                                st.cfg.burst8_allow, st.cfg.burst4_allow,
                                1'b0};
                            cfg_new = merge(cfg_word, writedata,
                                byteenable, `AXI_CFG_WMASK);
                            next_st.cfg.low_power_accept =
                                cfg_new[`BIT_LOW_POWER_ACCEPT];
                            next_st.cfg.wake_only_on_wake_pkt =
                                cfg_new[`BIT_WAKE_ONLY_PKT];
                            next_st.cfg.write_outstanding_limit =
                                cfg_new[`WR_OSR_MSB:`WR_OSR_LSB];
                            next_st.cfg.read_outstanding_limit =
                                cfg_new[`RD_OSR_MSB:`RD_OSR_LSB];
                            next_st.cfg.burst16_allow =
                                cfg_new[`BIT_BURST16];
                            next_st.cfg.burst8_allow = cfg_new[`BIT_BURST8];
                            next_st.cfg.burst4_allow = cfg_new[`BIT_BURST4];
                        end else if (hit(address, `OFS_IRQ_STAT)) begin
                            // write one to clear, new events still win
                            next_st.irq_stat = st.irq_stat
                                & ~merge(32'h0000_0000, writedata,
                                byteenable, `IRQ_EN_MASK);
                        end
                    end
                end
            end
            dma_ctrl_pkg::bus_answer: begin
                next_st.bus = dma_ctrl_pkg::bus_idle;
            end
            default: begin
                next_st.bus = dma_ctrl_pkg::bus_idle;
            end
        endcase

        // status sources after the bus: hardware sets beat any clear
        next_st.irq_stat = (next_st.irq_stat & ~irq_src_clr) | irq_src_set;

        // watchdog prescaler and timer
        if (st.wdog_run) begin
            next_st.prescale = st.prescale + 8'h01;
            if (st.prescale == 8'(`WDOG_UNIT_CYCLES - 1)) begin
                if (st.wdog_left == 8'h00) begin
                    next_st.irq_stat[`BIT_RX_DONE] = 1'b1;
                    next_st.wdog_run = 1'b0;
                end else begin
                    next_st.wdog_left = st.wdog_left - 8'h01;
                end
            end
        end
        if (rx_frame_done && rx_done_suppressed) begin
            next_st.wdog_run = 1'b1;
            next_st.prescale = 8'h00;
            next_st.wdog_left = st.rx_irq_wdog_count - 8'h01;
        end
        if (rx_frame_done && !rx_done_suppressed) begin
            next_st.wdog_run = 1'b0;
            next_st.irq_stat[`BIT_RX_DONE] = 1'b1;
        end
        if ((rx_frame_done && rx_done_suppressed)
            && st.rx_irq_wdog_count == 8'h00) begin
            next_st.wdog_run = 1'b0;
            next_st.irq_stat[`BIT_RX_DONE] = 1'b1;
        end

        // source gating by individual and summary enables
        irq_pending = st.irq_stat & st.irq_en
            & ((`NORMAL_SRC_MASK & {32{st.irq_en[`BIT_NORMAL_EN]}})
            | (`ABNORMAL_SRC_MASK
            & {32{st.irq_en[`BIT_ABNORMAL_EN]}}));
        next_st.irq = |irq_pending;

        next_st.lp_grant = low_power_req
            && st.cfg.low_power_accept;
        next_st.wake_req = st.cfg.wake_only_on_wake_pkt
            ? rx_wake_pkt : rx_any_frame;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st <= '0;
            st.waitrequest <= 1'b1;
            st.cfg.write_outstanding_limit <= `OSR_RESET;
            st.cfg.read_outstanding_limit <= `OSR_RESET;
            st.cfg.any_burst_len_flag <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign readdata = st.readdata;
    assign waitrequest = st.waitrequest;
    assign irq = st.irq;
    assign low_power_grant = st.lp_grant;
    assign wake_request = st.wake_req;
    assign axi_cfg = st.cfg;

endmodule // dma_irq_axi_ctrl

//--- verif/dma_ctrl_checker.sv
// assertions on the ports of the dma control register block
`timescale 1ns/10ps
module dma_ctrl_checker #(
    parameter int ADDR_W = 16
) (
    input wire logic clk_sys, // clock
    input wire logic reset, // reset
    input wire logic [ADDR_W-1:0] address, // address
    input wire logic read, // read
    input wire logic write, // write
    input wire logic [31:0] readdata, // read data
    input wire logic waitrequest, // stall
    input wire logic [31:0] irq_src_clr, // clear pulses
    input wire logic fixed_burst_setting, // fixed burst
    input wire logic rd_busy, // read channel busy
    input wire logic wr_busy, // write channel busy
    input wire logic low_power_req, // low power request
    input wire logic rx_any_frame, // any frame
    input wire logic rx_wake_pkt, // wake packet
    input wire logic irq, // interrupt
    input wire logic low_power_grant, // low power grant
    input wire logic wake_request, // wake request
    input wire dma_ctrl_pkg::axi_cfg_t axi_cfg // axi settings
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    property p_lp_grant;
        low_power_grant == $past(low_power_req && axi_cfg.low_power_accept);
    endproperty
    a_lp_grant: assert property (p_lp_grant)
        else $error("low power grant does not follow request");
    property p_lp_deny;
        !axi_cfg.low_power_accept [*2] |-> !low_power_grant;
    endproperty
    a_lp_deny: assert property (p_lp_deny)
        else $error("low power granted while disabled");
    property p_any_burst;
        !$past(reset) |->
            axi_cfg.any_burst_len_flag == !$past(fixed_burst_setting);
    endproperty
    a_any_burst: assert property (p_any_burst)
        else $error("any burst flag not inverse of fixed burst");
    property p_wake_only;
        $past(axi_cfg.wake_only_on_wake_pkt && !rx_wake_pkt) |-> !wake_request;
    endproperty
    a_wake_only: assert property (p_wake_only)
        else $error("wake request without wake packet");
    property p_wake_any;
        !$past(reset) && $past(!axi_cfg.wake_only_on_wake_pkt && rx_any_frame)
            |-> wake_request;
    endproperty
    a_wake_any: assert property (p_wake_any)
        else $error("no wake request on received frame");
    property p_osr_reset;
        $past(reset) |-> axi_cfg.write_outstanding_limit == 2'h1 &&
            axi_cfg.read_outstanding_limit == 2'h1;
    endproperty
    a_osr_reset: assert property (p_osr_reset)
        else $error("outstanding limits not 1 after reset");
    property p_cfg_write;
        $changed({axi_cfg.write_outstanding_limit, axi_cfg.burst16_allow,
            axi_cfg.read_outstanding_limit, axi_cfg.burst8_allow,
            axi_cfg.burst4_allow}) |->
            $past(write && address[15:2] == 14'h040a);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("axi settings changed without a write");
    property p_activity;
        !waitrequest && $past(read && address[15:2] == 14'h040b) |->
            readdata[1:0] == $past({rd_busy, wr_busy}, 2);
    endproperty
    a_activity: assert property (p_activity)
        else $error("channel activity read wrong");
    property p_irq_fall;
        $fell(irq) |-> $past(write || (|irq_src_clr)) ||
            $past(write || (|irq_src_clr), 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt dropped with no write or clear");
endmodule // dma_ctrl_checker

bind dma_irq_axi_ctrl dma_ctrl_checker #(.ADDR_W(ADDR_W)) chk_u (.clk_sys,
    .reset, .address, .read, .write, .readdata, .waitrequest, .irq_src_clr,
    .fixed_burst_setting, .rd_busy, .wr_busy, .low_power_req, .rx_any_frame,
    .rx_wake_pkt, .irq, .low_power_grant, .wake_request, .axi_cfg);

//--- verif/dma_far_side_model.sv
// far side model: axi channel activity and dma pointer updates
`timescale 1ns/10ps
module dma_far_side_model (
    input wire logic clk_sys, // clock
    input wire logic reset, // reset
    input wire logic go, // start a pointer update
    input wire dma_ctrl_pkg::dma_ptrs_t ptr_val, // pointer values
    input wire logic [1:0] busy_set, // read, write busy
    input wire logic [3:0] delay, // cycles before update
    output logic rd_busy, // read channel busy
    output logic wr_busy, // write channel busy
    output logic ptr_load, // pointer strobe
    output dma_ctrl_pkg::dma_ptrs_t ptr_in, // pointers
    output logic done // update delivered
);
    logic [3:0] wait_left;
    logic pending;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            {rd_busy, wr_busy, ptr_load, done, pending} <= '0;
            wait_left <= '0;
            ptr_in <= '0;
        end else begin
            ptr_load <= 1'b0;
            done <= 1'b0;
            {rd_busy, wr_busy} <= busy_set;
            if (ptr_load) begin
                ptr_in <= ~ptr_in;
            end
            if (go && !pending) begin
                pending <= 1'b1;
                wait_left <= delay;
            end else if (pending && wait_left != 4'h0) begin
                wait_left <= wait_left - 4'h1;
            end else if (pending) begin
                pending <= 1'b0;
                ptr_load <= 1'b1;
                ptr_in <= ptr_val;
                done <= 1'b1;
            end
        end
    end
endmodule // dma_far_side_model

//--- verif/dma_irq_axi_ctrl_tb_top.sv
// self-checking bench for the dma interrupt and axi settings block
`timescale 1ns/10ps
`include "dma_ctrl_defines.svh"
module dma_irq_axi_ctrl_tb_top;
    logic clk_sys, reset, read, write, ptr_load, done, go, irq;
    logic rd_busy, wr_busy, low_power_grant, wake_request, waitrequest;
    logic rx_fifo_overflow, rx_frame_discarded, rx_frame_done;
    logic rx_done_suppressed, fixed_burst_setting, aligned_beats;
    logic low_power_req, rx_any_frame, rx_wake_pkt;
    logic [15:0] address;
    logic [3:0] byteenable, delay;
    logic [31:0] writedata, readdata, irq_src_set, irq_src_clr, lfsr;
    logic [1:0] busy_set;
    dma_ctrl_pkg::dma_ptrs_t ptr_in, ptr_val;
    dma_ctrl_pkg::axi_cfg_t axi_cfg;
    logic [31:0] exp_q[$];
    int bad_count, checked, n;
    dma_irq_axi_ctrl dut_u (.clk_sys, .reset, .address, .read, .write,
        .byteenable, .writedata, .readdata, .waitrequest, .irq_src_set,
        .irq_src_clr, .rx_fifo_overflow, .rx_frame_discarded, .rx_frame_done,
        .rx_done_suppressed, .fixed_burst_setting, .aligned_beats, .rd_busy,
        .wr_busy, .ptr_load, .ptr_in, .low_power_req, .rx_any_frame,
        .rx_wake_pkt, .irq, .low_power_grant, .wake_request, .axi_cfg);
    dma_far_side_model far_u (.clk_sys, .reset, .go, .ptr_val, .busy_set,
        .delay, .rd_busy, .wr_busy, .ptr_load, .ptr_in, .done);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            bad_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk_sys);
    endtask
    // hold the request until waitrequest is sampled low, then idle a cycle
    task automatic bus(input logic rd, input logic [15:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        int w;
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= rd;
        write <= !rd;
        w = 0;
        do begin
            @(posedge clk_sys);
            w++;
        end while (waitrequest !== 1'b0 && w < 50);
        if (w >= 50) bad_count++;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e,
                          input logic [3:0] be);
        exp_q.push_back(e);
        bus(1'b1, a, 32'h0, be);
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        bus(1'b0, a, d, 4'hf);
    endtask
    task automatic irq_case(input int s);
        logic [31:0] b, good;
        b = 32'h1 << s;
        good = (`NORMAL_SRC_MASK & b) != 0 ? 32'h0001_0000 : 32'h0000_8000;
        wr(`OFS_IRQ_EN, b | (good ^ 32'h0001_8000));
        irq_src_set <= b;
        @(posedge clk_sys);
        irq_src_set <= 32'h0;
        tick(3);
        chk(32'(irq), 32'h0);
        wr(`OFS_IRQ_EN, b | good);
        rd_chk(`OFS_IRQ_EN, b | good, 4'hf);
        chk(32'(irq), 32'h1);
        wr(`OFS_IRQ_EN, good);
        tick(3);
        chk(32'(irq), 32'h0);
        wr(`OFS_IRQ_STAT, b);
        wr(`OFS_IRQ_EN, b | good);
        tick(3);
        chk(32'(irq), 32'h0);
    endtask
    task automatic wrap_up;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        if (read === 1'b1 && waitrequest === 1'b0) begin
            chk(readdata, exp_q.pop_front());
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #500us;
        bad_count++;
        wrap_up();
    end
    initial begin
        {reset, read, write, go, rx_fifo_overflow, rx_frame_discarded} = 6'h20;
        {rx_frame_done, rx_done_suppressed, fixed_burst_setting} = 3'h0;
        {aligned_beats, low_power_req, rx_any_frame, rx_wake_pkt} = 4'h0;
        {address, byteenable, writedata, irq_src_set, irq_src_clr} = '0;
        {busy_set, delay, ptr_val} = '0;
        lfsr = 32'h6809861e;
        tick(6);
        reset <= 1'b0;
        @(posedge clk_sys);
        rd_chk(`OFS_AXI_CFG, 32'h0011_0001, 4'hf);
        rd_chk(16'h1030, 32'h0, 4'hf);
        for (int i = 0; i < 4; i++) begin
            rd_chk(`OFS_TX_DESC + 16'(i * 4), 32'h0, 4'hf);
            lfsr = next_rand(lfsr);
            ptr_val[i*32 +: 32] <= lfsr;
        end
        delay <= lfsr[3:0];
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        wr(`OFS_TX_DESC, 32'hffff_ffff);
        for (int i = 0; i < 4; i++) begin
            rd_chk(`OFS_TX_DESC+16'(i*4), ptr_val[(3-i)*32+:32], 4'hf);
        end
        for (int b = 0; b < 4; b++) begin
            busy_set <= 2'(b);
            tick(3);
            rd_chk(`OFS_AXI_ACT, 32'(b), 4'hf);
        end
        wr(`OFS_AXI_CFG, 32'hffff_ffff);
        rd_chk(`OFS_AXI_CFG, 32'hc033_000f, 4'hf);
        low_power_req <= 1'b1;
        fixed_burst_setting <= 1'b1;
        aligned_beats <= 1'b1;
        tick(3);
        chk(32'(low_power_grant), 32'h1);
        wr(`OFS_AXI_CFG, 32'h0);
        rd_chk(`OFS_AXI_CFG, 32'h0000_1000, 4'hf);
        chk(32'(low_power_grant), 32'h0);
        for (int m = 0; m < 3; m++) begin
            wr(`OFS_AXI_CFG, {1'b0, m != 0, 30'h0});
            rx_any_frame <= (m != 2);
            rx_wake_pkt <= (m == 2);
            @(posedge clk_sys);
            rx_any_frame <= 1'b0;
            rx_wake_pkt <= 1'b0;
            @(posedge clk_sys);
            chk(32'(wake_request), 32'(m != 1));
        end
        for (int s = 0; s < 14; s++) begin
            if (s != 11 && s != 12) irq_case(s);
        end
        for (int i = 0; i < 2057; i++) begin
            rx_fifo_overflow <= 1'b1;
            rx_frame_discarded <= (i < 3);
            @(posedge clk_sys);
            rx_fifo_overflow <= 1'b0;
            rx_frame_discarded <= 1'b0;
            @(posedge clk_sys);
            if (i == 4) rd_chk(`OFS_MISSED, 32'h000a_0003, 4'h1);
            if (i == 4) rd_chk(`OFS_MISSED, 32'h000a_0000, 4'h4);
        end
        rd_chk(`OFS_MISSED, 32'h1008_0000, 4'h4);
        rd_chk(`OFS_MISSED, 32'h0, 4'hf);
        wr(`OFS_WDOG, 32'hffff_ff02);
        rd_chk(`OFS_WDOG, 32'h0000_0002, 4'hf);
        wr(`OFS_IRQ_EN, 32'h0001_0040);
        rx_done_suppressed <= 1'b1;
        rx_frame_done <= 1'b1;
        @(posedge clk_sys);
        rx_frame_done <= 1'b0;
        tick(2 * 256 - 8);
        chk(32'(irq), 32'h0);
        n = 0;
        while (irq !== 1'b1 && n < 16) begin
            @(posedge clk_sys);
            n++;
        end
        chk(32'(irq), 32'h1);
        irq_src_clr <= 32'h0000_0040;
        @(posedge clk_sys);
        irq_src_clr <= 32'h0;
        tick(3);
        chk(32'(irq), 32'h0);
        wrap_up();
    end
endmodule // dma_irq_axi_ctrl_tb_top
